// >>> hw/bsdp_pkg.sv
// Constants shared by the burst-of-two SRAM data port and its helpers.
// Assumes the includer picks the organisation through module parameters.
package bsdp_pkg;
   localparam int DATA_W_DEF    = 36;   // Widest organisation
   localparam int ADDR_W_DEF    = 19;   // One address per two-word burst
   localparam int BURST_LEN     = 2;
   localparam int BYTE_LANE_W   = 9;
   localparam int NIBBLE_LANE_W = 4;
   localparam int BYTE_MASK_N   = 4;
   localparam int NIBBLE_MASK_N = 2;
   localparam int CNT_W         = 16;
   localparam int SYNC_STAGES   = 2;
   // Read latency: first word half a cycle after this many full K cycles
   localparam int RD_FULL_CYCLES = 2;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic        BIT_RESET = 1'b0;
endpackage

// >>> hw/bsdp_sync.sv
// Two-flop level synchroniser into the destination clock domain.
// Assumes the source bits are quasi-static or toggle-coded events.
`timescale 1ns/1ps
module bsdp_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   import bsdp_pkg::*;

   logic [WIDTH-1:0] meta_q;

   initial
   begin
      if (WIDTH < 1)
         $error("bsdp_sync: WIDTH must be at least 1");
   end

   // First stage is read only by the second stage
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// >>> hw/bsdp_data_port.sv
// Data, load and write-mask port of a burst-of-two double-data-rate SRAM.
// Assumes the controller drives the link clock and is in phase with it;
// rising and falling link edges stand for the positive and negative
// input clocks. Activity counters are kept in the clk_in domain.
//
// How it works
// (R1) Write words captured on both clock edges
// (R2) Read words driven on both clock edges
// (R3) Data drivers off when no read active
// (R4) Load strobe low on rising edge starts cycle
// (R5) Every access moves exactly two words
// (R6) Nibble masks sampled with each data word
// (R7) Nibble zero bits 3:0, one bits 7:4
// (R8) Byte masks sampled with each data word
// (R9) Byte mask n gates nine-bit lane n
// (R10) Deselected lane keeps its stored contents
// (R11) Shared data pins sized by organisation
// (R12) Direction high reads, low writes
// (R13) Address sampled on rising edge
// (R14) Valid flag marks driven read data
// (R15) First read word 2.5 cycles after load
`timescale 1ns/1ps
module bsdp_data_port #(
   parameter int DATA_W = bsdp_pkg::DATA_W_DEF,
   parameter int ADDR_W = bsdp_pkg::ADDR_W_DEF
) (
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   input  wire logic                       link_clk_in,
   input  wire logic                       load_strobe_n_in,
   input  wire logic                       read_not_write_in,
   input  wire logic [ADDR_W-1:0]          addr_in,
   input  wire logic [DATA_W-1:0]          dq_in,
   input  wire logic [bsdp_pkg::BYTE_MASK_N-1:0]   byte_mask_n_in,
   input  wire logic [bsdp_pkg::NIBBLE_MASK_N-1:0] nibble_mask_n_in,
   output logic      [DATA_W-1:0]          dq_out,
   output logic                            dq_oe_out,
   output logic                            out_valid_out,
   output logic                            echo_timing_out,
   output logic      [bsdp_pkg::CNT_W-1:0] write_bursts_out,
   output logic      [bsdp_pkg::CNT_W-1:0] read_bursts_out
);
   import bsdp_pkg::*;

   // Organisation-derived lane geometry
   localparam bit NIBBLE_ORG = (DATA_W == 8);
   localparam int LANE_W     = NIBBLE_ORG ? NIBBLE_LANE_W : BYTE_LANE_W;
   localparam int LANES      = DATA_W / LANE_W;
   localparam int WORD2_W    = BURST_LEN * DATA_W;

   initial
   begin
      if (!(DATA_W == 8 || DATA_W == 9 || DATA_W == 18 || DATA_W == 36)) // (R11)
         $error("bsdp_data_port: DATA_W must be 8, 9, 18 or 36");
      if (ADDR_W < 1 || ADDR_W > 24)
         $error("bsdp_data_port: ADDR_W out of range");
   end

   // Active-low lane selects for the current organisation
   function automatic logic [LANES-1:0] lane_sel_n(
      input logic [BYTE_MASK_N-1:0]   bmask_n,
      input logic [NIBBLE_MASK_N-1:0] nmask_n
   );
      logic [LANES-1:0] sel;
      sel = '1;
      for (int i = 0; i < LANES; i++)
      begin
         // Modulo keeps the unused nibble index in range for byte organisations
         sel[i] = NIBBLE_ORG ? nmask_n[i % NIBBLE_MASK_N] : bmask_n[i]; // (R6) (R8)
      end
      return sel;
   endfunction

   // Merge a new word into an old one, lane by lane
   function automatic logic [DATA_W-1:0] merge_word(
      input logic [DATA_W-1:0] old_word,
      input logic [DATA_W-1:0] new_word,
      input logic [LANES-1:0]  sel_n
   );
      logic [DATA_W-1:0] res;
      res = old_word;
      for (int i = 0; i < LANES; i++)
      begin
         // Lane i covers bits starting at i*LANE_W (nibble or nine-bit byte)
         if (!sel_n[i]) // (R7) (R9)
            res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
      end
      return res; // (R10)
   endfunction

   // Two words per address, word 0 in the low half
   logic [WORD2_W-1:0] mem [0:(1<<ADDR_W)-1];

   // Rising-edge command capture
   logic              cmd_rd_q;
   logic              cmd_wr_q;
   logic [ADDR_W-1:0] cmd_addr_q;

   // Write path
   logic [DATA_W-1:0] w0_data_q;
   logic [LANES-1:0]  w0_sel_n_q;
   logic [ADDR_W-1:0] w_addr_q;
   logic              w_pend_q;
   logic [DATA_W-1:0] w1_data_nq;
   logic [LANES-1:0]  w1_sel_n_nq;

   // Read path
   logic [WORD2_W-1:0] rd_data1_q;
   logic [WORD2_W-1:0] rd_data2_q;
   logic               rd_stage1_q;
   logic               rd_stage2_q;

   // Output flops, one set per edge
   logic [DATA_W-1:0] dq_p_q;
   logic              oe_p_q;
   logic [DATA_W-1:0] dq_n_q;
   logic              oe_n_q;
   logic              echo_p_q;
   logic              echo_n_q;

   // Event toggles toward clk_in
   logic wr_tgl_q;
   logic rd_tgl_q;

   wire               load_seen   = !load_strobe_n_in;          // (R4)
   wire               load_read   = load_seen && read_not_write_in;  // (R12)
   wire               load_write  = load_seen && !read_not_write_in; // (R12)
   wire [LANES-1:0]   sel_n_now   = lane_sel_n(byte_mask_n_in, nibble_mask_n_in);
   wire [WORD2_W-1:0] w_old       = mem[w_addr_q];
   wire [DATA_W-1:0]  w_new0      = merge_word(w_old[DATA_W-1:0], w0_data_q, w0_sel_n_q);
   wire [DATA_W-1:0]  w_new1      = merge_word(w_old[WORD2_W-1:DATA_W], w1_data_nq,
                                               w1_sel_n_nq);
   wire [DATA_W-1:0]  rd_word0    = rd_data2_q[DATA_W-1:0];
   wire [DATA_W-1:0]  rd_word1    = rd_data2_q[WORD2_W-1:DATA_W];

   // Command capture on the rising edge
   always_ff @(posedge link_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cmd_rd_q   <= BIT_RESET;
         cmd_wr_q   <= BIT_RESET;
         cmd_addr_q <= '0;
      end
      else
      begin
         cmd_rd_q   <= load_read;
         cmd_wr_q   <= load_write;
         cmd_addr_q <= addr_in; // (R13)
      end
   end

   // First write word one rising edge after the load
   always_ff @(posedge link_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         w0_data_q  <= '0;
         w0_sel_n_q <= '1;
         w_addr_q   <= '0;
         w_pend_q   <= BIT_RESET;
      end
      else
      begin
         w_pend_q <= cmd_wr_q;
         if (cmd_wr_q)
         begin
            w0_data_q  <= dq_in;     // (R1)
            w0_sel_n_q <= sel_n_now; // (R6) (R8)
            w_addr_q   <= cmd_addr_q;
         end
      end
   end

   // Second write word on the falling edge; captured every cycle, used only when pending
   always_ff @(negedge link_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         w1_data_nq  <= '0;
         w1_sel_n_nq <= '1;
      end
      else
      begin
         w1_data_nq  <= dq_in;     // (R1)
         w1_sel_n_nq <= sel_n_now; // (R6) (R8)
      end
   end

   // Both words of a burst commit together, so a burst is never half written
   always_ff @(posedge link_clk_in)
   begin
      if (w_pend_q)
         mem[w_addr_q] <= {w_new1, w_new0}; // (R5) (R10)
   end

   // Array read one edge after the load, then one holding stage
   always_ff @(posedge link_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rd_data1_q  <= '0;
         rd_data2_q  <= '0;
         rd_stage1_q <= BIT_RESET;
         rd_stage2_q <= BIT_RESET;
      end
      else
      begin
         rd_stage1_q <= cmd_rd_q;
         rd_stage2_q <= rd_stage1_q;
         rd_data2_q  <= rd_data1_q;
         if (cmd_rd_q)
            rd_data1_q <= mem[cmd_addr_q]; // (R5)
      end
   end

   // Falling edge after the second full cycle: first word out
   always_ff @(negedge link_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         dq_n_q   <= '0;
         oe_n_q   <= BIT_RESET;
         echo_n_q <= BIT_RESET;
      end
      else
      begin
         dq_n_q   <= rd_stage2_q ? rd_word0 : '0; // (R2) (R15)
         oe_n_q   <= rd_stage2_q;                 // (R3)
         echo_n_q <= 1'b0;
      end
   end

   // Following rising edge: second word out
   always_ff @(posedge link_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         dq_p_q   <= '0;
         oe_p_q   <= BIT_RESET;
         echo_p_q <= BIT_RESET;
      end
      else
      begin
         dq_p_q   <= rd_stage2_q ? rd_word1 : '0; // (R2) (R5)
         oe_p_q   <= rd_stage2_q;                 // (R3)
         echo_p_q <= 1'b1;
      end
   end

   // Edge-selected output stage: high phase shows the rising-edge flops
   assign dq_out          = link_clk_in ? dq_p_q : dq_n_q;   // (R2) (R11)
   assign dq_oe_out       = link_clk_in ? oe_p_q : oe_n_q;   // (R3)
   assign out_valid_out   = link_clk_in ? oe_p_q : oe_n_q;   // (R14)
   assign echo_timing_out = link_clk_in ? echo_p_q : echo_n_q;

   // One toggle per committed write burst and per fetched read burst
   always_ff @(posedge link_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wr_tgl_q <= BIT_RESET;
         rd_tgl_q <= BIT_RESET;
      end
      else
      begin
         wr_tgl_q <= wr_tgl_q ^ w_pend_q;
         rd_tgl_q <= rd_tgl_q ^ cmd_rd_q;
      end
   end

   // Toggle crossing into clk_in; a third flop finds the change
   logic [1:0] tgl_sync;
   logic [1:0] tgl_prev_q;

   bsdp_sync #(
      .WIDTH (2)
   ) u_tgl_sync (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .async_in ({rd_tgl_q, wr_tgl_q}),
      .sync_out (tgl_sync)
   );

   wire wr_event = tgl_sync[0] ^ tgl_prev_q[0];
   wire rd_event = tgl_sync[1] ^ tgl_prev_q[1];

   // Counters wrap; software-free block so no clear is offered
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         tgl_prev_q       <= 2'h0;
         write_bursts_out <= CNT_RESET;
         read_bursts_out  <= CNT_RESET;
      end
      else
      begin
         tgl_prev_q <= tgl_sync;
         if (wr_event)
            write_bursts_out <= write_bursts_out + 16'h0001;
         if (rd_event)
            read_bursts_out <= read_bursts_out + 16'h0001;
      end
   end
endmodule

// >>> sim/bsdp_data_port_sva.sv
// Pin-level checks of the data port: read drivers, echo and counters.
// Assumes the bind below reaches every data port instance.
`timescale 1ns/1ps
module bsdp_data_port_sva (
   input wire logic                       clk_in,
   input wire logic                       rst_in,
   input wire logic                       link_clk_in,
   input wire logic                       load_strobe_n_in,
   input wire logic                       read_not_write_in,
   input wire logic                       dq_oe_out,
   input wire logic                       out_valid_out,
   input wire logic                       echo_timing_out,
   input wire logic [bsdp_pkg::CNT_W-1:0] write_bursts_out,
   input wire logic [bsdp_pkg::CNT_W-1:0] read_bursts_out
);
   import bsdp_pkg::*;
   wire        rd_load = !load_strobe_n_in && read_not_write_in;
   logic [3:0] rd_sh_q;
   // Age of each read load in rising edges, to predict both output halves
   always_ff @(posedge link_clk_in or posedge rst_in)
   begin
      if (rst_in) rd_sh_q <= 4'h0;
      else rd_sh_q <= {rd_sh_q[2:0], rd_load};
   end
   a_oe_first_word: assert property (@(posedge link_clk_in) disable iff (rst_in)
      dq_oe_out == rd_sh_q[2]) else $error("driver state wrong in first word");
   a_oe_second_word: assert property (@(negedge link_clk_in) disable iff (rst_in)
      dq_oe_out == rd_sh_q[3]) else $error("driver state wrong in second word");
   a_valid_low_phase: assert property (@(posedge link_clk_in) disable iff (rst_in)
      out_valid_out == rd_sh_q[2]) else $error("valid wrong in first word");
   a_valid_high_phase: assert property (@(negedge link_clk_in) disable iff (rst_in)
      out_valid_out == rd_sh_q[3]) else $error("valid wrong in second word");
   // A read load, then driver and valid both up while the first word stands
   sequence s_read_load;
      !load_strobe_n_in && read_not_write_in;
   endsequence
   sequence s_first_word_up;
      ##3 (dq_oe_out && out_valid_out);
   endsequence
   a_read_word_up: assert property (@(posedge link_clk_in) disable iff (rst_in)
      s_read_load |-> s_first_word_up) else $error("first read word not driven");
   a_echo_after_fall: assert property (@(posedge link_clk_in) disable iff (rst_in)
      !echo_timing_out) else $error("echo high after falling edge");
   a_echo_after_rise: assert property (@(negedge link_clk_in) disable iff (rst_in)
      !$past(rst_in) |-> echo_timing_out) else $error("echo low after rising edge");
   a_write_count_step: assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(write_bursts_out) |-> write_bursts_out == $past(write_bursts_out) + 16'h0001)
      else $error("write count jumped");
   a_read_count_step: assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(read_bursts_out) |-> read_bursts_out == $past(read_bursts_out) + 16'h0001)
      else $error("read count jumped");
endmodule
bind bsdp_data_port bsdp_data_port_sva u_bsdp_data_port_sva (.clk_in, .rst_in, .link_clk_in,
   .load_strobe_n_in, .read_not_write_in, .dq_oe_out, .out_valid_out, .echo_timing_out,
   .write_bursts_out, .read_bursts_out);

// >>> sim/bsdp_ctrl_model.sv
// Memory controller model: one two-word burst at a time on the link clock.
// Assumes the bench owns the link clock and calls burst().
`timescale 1ns/1ps
module bsdp_ctrl_model #(
   parameter int DATA_W = 36,
   parameter int ADDR_W = 8
) (
   input  wire logic              link_clk_in,
   input  wire logic [DATA_W-1:0] rd_data_in,
   input  wire logic              rd_oe_in,
   output logic                   load_strobe_n_out,
   output logic                   rnw_out,
   output logic      [ADDR_W-1:0] addr_out,
   output logic      [DATA_W-1:0] dq_out,
   output logic      [3:0]        mask_n_out
);
   initial
   begin
      load_strobe_n_out <= 1'b1;
      rnw_out <= 1'b0;
      addr_out <= '0;
      dq_out <= '0;
      mask_n_out <= 4'hf;
   end
   // Released lines show inverted values so stale data is never sampled
   task automatic burst(input logic rw, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] w0, w1, input logic [3:0] m0, m1,
      output logic [DATA_W-1:0] r0, r1, output logic [2:0] oe);
      @(posedge link_clk_in);
      load_strobe_n_out <= 1'b0;
      rnw_out <= rw;
      addr_out <= a;
      @(posedge link_clk_in);
      load_strobe_n_out <= 1'b1;
      rnw_out <= ~rw;
      addr_out <= ~a;
      dq_out <= w0;
      mask_n_out <= m0;
      @(posedge link_clk_in);
      dq_out <= w1;
      mask_n_out <= m1;
      @(negedge link_clk_in);
      dq_out <= ~w1;
      mask_n_out <= ~m1;
      @(negedge link_clk_in);
      #3 r0 = rd_data_in;
      oe[0] = rd_oe_in;
      @(posedge link_clk_in);
      #3 r1 = rd_data_in;
      oe[1] = rd_oe_in;
      @(negedge link_clk_in);
      #3 oe[2] = rd_oe_in;
      // Spacing keeps counter events apart in the slower core clock
      repeat (6) @(posedge link_clk_in);
   endtask
endmodule

// >>> sim/tb_bsdp_data_port.sv
// Self-checking bench: random bursts against a reference memory.
// Assumes the controller model shares the link clock with the port.
`timescale 1ns/1ps
module tb_bsdp_data_port;
   import bsdp_pkg::*;
   logic        clk = 1'b0, lclk = 1'b0, rst = 1'b1, ld_n, rnw, oe, vld, echo;
   logic [7:0]  addr, mk;
   logic [35:0] dq_w, dq_r;
   logic [3:0]  bm_n;
   logic [15:0] wcnt, rcnt, nw = 16'h0000, nr = 16'h0000;
   logic [71:0] ref_q [16];
   logic [7:0]  dq_r8;
   logic [15:0] ref8 [16];
   integer      seed = 32'he19e;
   int          num_checks = 0, n_mismatch = 0;
   bsdp_data_port #(.DATA_W(36), .ADDR_W(8)) u_bsdp_data_port (.clk_in(clk), .rst_in(rst),
      .link_clk_in(lclk), .load_strobe_n_in(ld_n), .read_not_write_in(rnw), .addr_in(addr),
      .dq_in(dq_w), .byte_mask_n_in(bm_n), .nibble_mask_n_in(2'h0), .dq_out(dq_r),
      .dq_oe_out(oe), .out_valid_out(vld), .echo_timing_out(echo),
      .write_bursts_out(wcnt), .read_bursts_out(rcnt));
   // Nibble organisation shares the link; its masks are the low two mask lines
   bsdp_data_port #(.DATA_W(8), .ADDR_W(8)) u_bsdp_data_port_8 (.clk_in(clk),
      .rst_in(rst), .link_clk_in(lclk), .load_strobe_n_in(ld_n),
      .read_not_write_in(rnw), .addr_in(addr), .dq_in(dq_w[7:0]),
      .byte_mask_n_in(bm_n), .nibble_mask_n_in(bm_n[1:0]), .dq_out(dq_r8),
      .dq_oe_out(), .out_valid_out(), .echo_timing_out(), .write_bursts_out(),
      .read_bursts_out());
   bsdp_ctrl_model #(.DATA_W(36), .ADDR_W(8)) u_bsdp_ctrl_model (.link_clk_in(lclk),
      .rd_data_in(dq_r), .rd_oe_in(oe), .load_strobe_n_out(ld_n), .rnw_out(rnw),
      .addr_out(addr), .dq_out(dq_w), .mask_n_out(bm_n));
   initial
   begin
      forever #20 clk = ~clk;
   end
   initial
   begin
      #3.7;
      forever #6 lclk = ~lclk;
   end
   function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] m);
      merge = o;
      for (int i = 0; i < 4; i++)
         if (!m[i]) merge[i*9 +: 9] = n[i*9 +: 9];
   endfunction
   function automatic logic [7:0] merge8(input logic [7:0] o, n, input logic [1:0] m);
      merge8 = o;
      for (int i = 0; i < 2; i++)
         if (!m[i]) merge8[i*4 +: 4] = n[i*4 +: 4];
   endfunction
   task automatic chk_data(input logic [35:0] got, exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t data %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic [2:0] got, exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t driver flags %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input logic [15:0] got, exp);
      // Counters move on clk edges; look once they have settled
      #1;
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [3:0] m0, m1);
      logic [63:0] t0, t1;
      logic [35:0] r0, r1;
      logic [2:0]  f;
      t0 = {$random(seed), $random(seed)};
      t1 = {$random(seed), $random(seed)};
      u_bsdp_ctrl_model.burst(1'b0, {4'h0, a}, t0[35:0], t1[35:0], m0, m1, r0, r1, f);
      ref_q[a][35:0] = merge(ref_q[a][35:0], t0[35:0], m0);
      ref_q[a][71:36] = merge(ref_q[a][71:36], t1[35:0], m1);
      ref8[a][7:0] = merge8(ref8[a][7:0], t0[7:0], m0[1:0]);
      ref8[a][15:8] = merge8(ref8[a][15:8], t1[7:0], m1[1:0]);
      chk_flag(f, 3'h0);
      nw++;
   endtask
   task automatic rd(input logic [3:0] a);
      logic [35:0] r0, r1;
      logic [7:0]  s0, s1;
      logic [2:0]  f;
      fork
         u_bsdp_ctrl_model.burst(1'b1, {4'h0, a}, '0, '0, 4'h0, 4'h0, r0, r1, f);
         begin
            // Narrow port sampled at the same points as the model samples
            repeat (3) @(posedge lclk);
            repeat (2) @(negedge lclk);
            #3 s0 = dq_r8;
            @(posedge lclk);
            #3 s1 = dq_r8;
         end
      join
      chk_data({28'h000_0000, s0}, {28'h000_0000, ref8[a][7:0]});
      chk_data({28'h000_0000, s1}, {28'h000_0000, ref8[a][15:8]});
      chk_data(r0, ref_q[a][35:0]);
      chk_data(r1, ref_q[a][71:36]);
      chk_flag(f, 3'h3);
      nr++;
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 16; i++) wr(4'(i), 4'h0, 4'h0);
      wr(4'h5, 4'hf, 4'h0);
      rd(4'h5);
      for (int k = 0; k < 90; k++)
      begin
         addr_pick: mk = 8'($random(seed));
         if (k % 3 == 0) rd(mk[3:0]);
         else wr(mk[3:0], mk[7:4], mk[3:0] ^ mk[7:4]);
      end
      repeat (10) @(posedge clk);
      chk_cnt(wcnt, nw);
      chk_cnt(rcnt, nr);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk_cnt(wcnt, 16'h0000);
      chk_cnt(rcnt, 16'h0000);
      nw = 16'h0000;
      nr = 16'h0000;
      wr(4'h2, 4'h6, 4'h9);
      rd(4'h2);
      repeat (10) @(posedge clk);
      chk_cnt(rcnt, nr);
      chk_cnt(wcnt, nw);
      test_done;
   end
   initial
   begin
      #100000;
      n_mismatch++;
      test_done;
   end
endmodule
